// [sim/sfq_frontend_bench.sv]
`timescale 1ns/1ps
`include "sfq_consts.vh"
module sfq_frontend_bench;
    // Clock, reset and level inputs
    reg         mclk = 1'b0;
    reg         rst = 1'b1;
    reg         four_line_command_mode = 1'b1;
    reg  [7:0]  status1 = 8'hA1, status2 = 8'h5C, status3 = 8'h36;
    reg  [7:0]  id_byte = 8'h00, array_data = 8'h96;
    // Link and outputs
    wire        sclk, cs_n;
    wire [3:0]  h_io, h_oe, d_out, d_oe, io, dummy_clocks;
    wire        write_enable_latch, volatile_wr_enable, suspend_req, resume_req;
    wire        status_wr, status_wr_two, page_wr;
    wire [15:0] status_wr_data;
    wire [23:0] page_wr_addr, read_addr;
    wire [7:0]  page_wr_data, read_parameter_byte;
    wire [1:0]  sec_reg_sel;
    integer     n_fail = 0, checks_done = 0, n_susp = 0, n_res = 0, n_page = 0, n_stwr = 0;
    integer     i, k;
    reg  [7:0]  got;
    reg  [23:0] ops = {`SFQ_OP_RDSR1, `SFQ_OP_RDSR2, `SFQ_OP_RDSR3};
    always #5 mclk = ~mclk;
    // Host wins, then device; a line nobody drives shows the inverse of the host's last value
    assign io = (h_oe & h_io) | (~h_oe & d_oe & d_out) | (~h_oe & ~d_oe & ~h_io);
    // Pulse counters
    always @(posedge mclk) begin
        if (suspend_req === 1'b1) n_susp = n_susp + 1;
        if (resume_req === 1'b1) n_res = n_res + 1;
        if (page_wr === 1'b1) n_page = n_page + 1;
        if (status_wr === 1'b1) n_stwr = n_stwr + 1;
    end
    sfq_frontend sfq_frontend_inst (.mclk, .rst, .sclk, .cs_n, .quad_data_lines_in(io),
        .quad_data_lines_out(d_out), .quad_data_lines_oe(d_oe), .four_line_command_mode,
        .status1, .status2, .status3, .id_byte, .array_data, .write_enable_latch,
        .volatile_wr_enable, .suspend_req, .resume_req, .status_wr, .status_wr_data,
        .status_wr_two, .page_wr, .page_wr_addr, .page_wr_data, .read_addr, .sec_reg_sel,
        .read_parameter_byte, .dummy_clocks);
    sfq_host_model sfq_host_model_inst (.mclk, .sclk, .cs_n, .h_io, .h_oe, .io);
    task check(input [31:0] seen, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("BAD %0t saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task test_done;
        begin
            $display("checks %0d failures %0d", checks_done, n_fail);
            if (n_fail == 0 && checks_done > 0) $display("Result: passed");
            else $display("Result: failed");
            $finish;
        end
    endtask
    // Quad frame of up to three host bytes
    task qcmd(input [7:0] a, input [7:0] b, input [7:0] c, input integer n);
        begin
            sfq_host_model_inst.start_frame;
            sfq_host_model_inst.qbyte(a, 4'hF, got);
            if (n > 1) sfq_host_model_inst.qbyte(b, 4'hF, got);
            if (n > 2) sfq_host_model_inst.qbyte(c, 4'hF, got);
            sfq_host_model_inst.end_frame;
        end
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        qcmd(`SFQ_OP_WREN, 8'h00, 8'h00, 1);
        check(write_enable_latch, 1);
        qcmd(`SFQ_OP_VWREN, 8'h00, 8'h00, 1);
        check(volatile_wr_enable, 1);
        qcmd(`SFQ_OP_WRDI, 8'h00, 8'h00, 1);
        check(write_enable_latch, 0);
        // Unknown opcode swallows the rest of its frame
        qcmd(8'hA5, `SFQ_OP_WREN, 8'h00, 2);
        check(write_enable_latch, 0);
        qcmd(`SFQ_OP_SUSP, 8'h00, 8'h00, 1);
        qcmd(`SFQ_OP_RESUME, 8'h00, 8'h00, 1);
        check(n_susp, 1);
        check(n_res, 1);
        // Each status byte comes out twice in one frame
        for (k = 0; k < 3; k = k + 1) begin
            sfq_host_model_inst.start_frame;
            sfq_host_model_inst.qbyte(ops[23-8*k -: 8], 4'hF, got);
            for (i = 0; i < 2; i = i + 1) begin
                sfq_host_model_inst.qbyte(8'h00, 4'h0, got);
                check(got, k == 0 ? status1 : k == 1 ? status2 : status3);
            end
            sfq_host_model_inst.end_frame;
        end
        qcmd(`SFQ_OP_WRSR1, 8'h3C, 8'hC3, 3);
        check(n_stwr, 1);
        check(status_wr_two, 1);
        check(status_wr_data, 16'hC33C);
        // Seventeen bytes from offset F0 cross the page end
        sfq_host_model_inst.start_frame;
        sfq_host_model_inst.qbyte(`SFQ_OP_PP, 4'hF, got);
        sfq_host_model_inst.qbyte(8'h34, 4'hF, got);
        sfq_host_model_inst.qbyte(8'h56, 4'hF, got);
        sfq_host_model_inst.qbyte(8'hF0, 4'hF, got);
        for (i = 0; i < 17; i = i + 1) sfq_host_model_inst.qbyte(i[7:0], 4'hF, got);
        sfq_host_model_inst.end_frame;
        check(n_page, 17);
        check(page_wr_addr, 24'h345600);
        check(page_wr_data, 8'h10);
        qcmd(`SFQ_OP_SETPARAM, 8'h53, 8'h00, 2);
        check(read_parameter_byte, 8'h53);
        // Burst read: five dummy clocks from the parameter, then data
        sfq_host_model_inst.start_frame;
        sfq_host_model_inst.qbyte(`SFQ_OP_BURST, 4'hF, got);
        for (i = 0; i < 3; i = i + 1) sfq_host_model_inst.qbyte(8'h11 * i[7:0], 4'hF, got);
        for (i = 0; i < 5; i = i + 1) sfq_host_model_inst.nib(4'h0, 4'h0, got[3:0]);
        sfq_host_model_inst.qbyte(8'h00, 4'h0, got);
        check(got, 8'h96);
        sfq_host_model_inst.end_frame;
        // The address has already stepped past the one byte taken
        check(read_addr, 24'h001123);
        check(dummy_clocks, 4'h5);
        // Single-line mode; an empty frame lets the mode be taken at deselect
        @(posedge mclk) four_line_command_mode <= 1'b0;
        sfq_host_model_inst.start_frame;
        sfq_host_model_inst.end_frame;
        sfq_host_model_inst.start_frame;
        sfq_host_model_inst.sbyte(`SFQ_OP_RDSEC, got);
        sfq_host_model_inst.sbyte(`SFQ_SEC_HI, got);
        sfq_host_model_inst.sbyte(`SFQ_SEC_R2, got);
        sfq_host_model_inst.sbyte(8'h10, got);
        sfq_host_model_inst.end_frame;
        check(sec_reg_sel, 2);
        check(read_addr, 24'h002010);
        // Single-line status read comes back on line one
        sfq_host_model_inst.start_frame;
        sfq_host_model_inst.sbyte(`SFQ_OP_RDSR1, got);
        sfq_host_model_inst.sbyte(8'h00, got);
        check(got, status1);
        sfq_host_model_inst.end_frame;
        // Set wrap: bits only on lines 0..2 of the seventh quad clock
        sfq_host_model_inst.start_frame;
        sfq_host_model_inst.sbyte(`SFQ_OP_SETWRAP, got);
        for (i = 0; i < 3; i = i + 1) sfq_host_model_inst.qbyte(8'h00, 4'hF, got);
        sfq_host_model_inst.qbyte(8'h70, 4'hF, got);
        sfq_host_model_inst.end_frame;
        // Quad I/O read from offset F: wrap keeps the address in its 16 bytes
        sfq_host_model_inst.start_frame;
        sfq_host_model_inst.sbyte(`SFQ_OP_QIOREAD, got);
        sfq_host_model_inst.qbyte(8'hAB, 4'hF, got);
        sfq_host_model_inst.qbyte(8'hCD, 4'hF, got);
        sfq_host_model_inst.qbyte(8'hEF, 4'hF, got);
        sfq_host_model_inst.qbyte(8'h00, 4'hF, got);
        // Ten dummies: eight plus the count in status byte three
        for (i = 0; i < 10; i = i + 1) sfq_host_model_inst.nib(4'h0, 4'h0, got[3:0]);
        for (i = 0; i < 2; i = i + 1) begin
            sfq_host_model_inst.qbyte(8'h00, 4'h0, got);
            check(got, array_data);
        end
        sfq_host_model_inst.end_frame;
        check(read_addr, 24'hABCDE1);
        check(dummy_clocks, 4'hA);
        // Dual I/O read: address and mode byte on lines 1:0, four-clock data
        sfq_host_model_inst.start_frame;
        sfq_host_model_inst.sbyte(`SFQ_OP_DIOREAD, got);
        sfq_host_model_inst.dbyte(8'h12, 4'h3, got);
        sfq_host_model_inst.dbyte(8'h34, 4'h3, got);
        sfq_host_model_inst.dbyte(8'h56, 4'h3, got);
        sfq_host_model_inst.dbyte(8'h00, 4'h3, got);
        for (i = 0; i < 10; i = i + 1) sfq_host_model_inst.nib(4'h0, 4'h0, got[3:0]);
        sfq_host_model_inst.dbyte(8'h00, 4'h0, got);
        check(got, array_data);
        sfq_host_model_inst.end_frame;
        check(read_addr, 24'h123457);
        check(sec_reg_sel, 0);
        test_done;
    end
    // Whole run is well under 60 us of link traffic
    initial begin
        #400000;
        n_fail = n_fail + 1;
        test_done;
    end
endmodule // sfq_frontend_bench

// [sim/sfq_frontend_props.sv]
`timescale 1ns/1ps
module sfq_frontend_props (
    // Clock and reset
    input wire       mclk,
    input wire       rst,
    // Link pins
    input wire       sclk,
    input wire       cs_n,
    input wire [3:0] quad_data_lines_out,
    input wire [3:0] quad_data_lines_oe,
    // Decoded events
    input wire       write_enable_latch,
    input wire       suspend_req,
    input wire       resume_req,
    input wire       status_wr,
    input wire       page_wr
);
    // Single domain, so clock and reset are given once
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Six cycles of margin cover the two-flop delay on chip select
    a_idle_no_drive: assert property (cs_n [*6] |-> quad_data_lines_oe == 4'h0)
        else $error("lines driven while deselected");
    a_lane_width: assert property (quad_data_lines_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
        else $error("output enable not one, two or four lines");
    a_susp_pulse: assert property (suspend_req |=> !suspend_req)
        else $error("suspend request longer than one cycle");
    a_resume_pulse: assert property (resume_req |=> !resume_req)
        else $error("resume request longer than one cycle");
    a_susp_excl: assert property (!(suspend_req && resume_req))
        else $error("suspend and resume together");
    a_page_pulse: assert property (page_wr |=> !page_wr)
        else $error("page write pulse too long");
    a_stwr_pulse: assert property (status_wr |=> !status_wr)
        else $error("status write pulse too long");
    a_latch_quiet: assert property ($changed(write_enable_latch) |-> quad_data_lines_oe == 4'h0)
        else $error("write latch moved during a read");
    a_out_hold: assert property (sclk [*6] |-> $stable(quad_data_lines_out))
        else $error("output moved while link clock high");
endmodule // sfq_frontend_props
bind sfq_frontend sfq_frontend_props sfq_frontend_props_inst (.mclk, .rst, .sclk, .cs_n,
    .quad_data_lines_out, .quad_data_lines_oe, .write_enable_latch, .suspend_req,
    .resume_req, .status_wr, .page_wr);

// [sim/sfq_host_model.sv]
`timescale 1ns/1ps
module sfq_host_model (
    // Bench clock, used only to pick an edge-free phase
    input  wire       mclk,
    // Link pins toward the device
    output reg        sclk,
    output reg        cs_n,
    output reg  [3:0] h_io,
    output reg  [3:0] h_oe,
    // Resolved lines
    input  wire [3:0] io
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        h_io = 4'h0;
        h_oe = 4'h0;
    end
    // Offset keeps link edges away from both mclk edges
    task start_frame;
        begin
            @(negedge mclk) #1.25 cs_n = 1'b0;
            #62.5;
        end
    endtask
    // Released lines keep the old value so the bench shows its inverse
    task nib(input [3:0] v, input [3:0] oe, output [3:0] r);
        begin
            h_io = (v & oe) | (h_io & ~oe);
            h_oe = oe;
            #62.5 sclk = 1'b1;
            r = io;
            #62.5 sclk = 1'b0;
        end
    endtask
    // Upper nibble first, two clocks a byte
    task qbyte(input [7:0] b, input [3:0] oe, output [7:0] r);
        reg [3:0] hi, lo;
        begin
            nib(b[7:4], oe, hi);
            nib(b[3:0], oe, lo);
            r = {hi, lo};
        end
    endtask
    // Single line zero out, line one back, MSB first
    task sbyte(input [7:0] b, output [7:0] r);
        integer j;
        reg [3:0] d;
        begin
            for (j = 7; j >= 0; j = j - 1) begin
                nib({3'b000, b[j]}, 4'h1, d);
                r[j] = d[1];
            end
        end
    endtask
    // Two lines: line one odd bits, line zero even bits, MSB pair first
    task dbyte(input [7:0] b, input [3:0] oe, output [7:0] r);
        integer j;
        reg [3:0] d;
        begin
            for (j = 3; j >= 0; j = j - 1) begin
                nib({2'b00, b[2*j+1], b[2*j]}, oe, d);
                r[2*j+1] = d[1];
                r[2*j]   = d[0];
            end
        end
    endtask
    // Deselect only on a byte boundary; clock rests low between frames
    task end_frame;
        begin
            h_oe = 4'h0;
            #62.5 cs_n = 1'b1;
            #250;
            @(negedge mclk);
        end
    endtask
endmodule // sfq_host_model

// [src/sfq_consts.vh]
`ifndef SFQ_CONSTS_VH
`define SFQ_CONSTS_VH
// Opcodes
`define SFQ_OP_WREN      8'h06
`define SFQ_OP_VWREN     8'h50
`define SFQ_OP_WRDI      8'h04
`define SFQ_OP_RDSR1     8'h05
`define SFQ_OP_RDSR2     8'h35
`define SFQ_OP_RDSR3     8'h15
`define SFQ_OP_WRSR1     8'h01
`define SFQ_OP_SUSP      8'h75
`define SFQ_OP_RESUME    8'h7A
`define SFQ_OP_PP        8'h02
`define SFQ_OP_FREAD     8'h0B
`define SFQ_OP_BURST     8'h0C
`define SFQ_OP_QIOREAD   8'hEB
`define SFQ_OP_SETPARAM  8'hC0
`define SFQ_OP_JEDEC     8'h9F
`define SFQ_OP_RDSEC     8'h48
`define SFQ_OP_DIOREAD   8'hBB
`define SFQ_OP_SETWRAP   8'h77
// Security area decode
`define SFQ_SEC_HI       8'h00
`define SFQ_SEC_R1       8'h10
`define SFQ_SEC_R2       8'h20
`define SFQ_SEC_R3       8'h30
// Field positions
`define SFQ_P_DUMMY_HI   7
`define SFQ_P_DUMMY_LO   4
`define SFQ_P_WRAP_HI    3
`define SFQ_P_WRAP_LO    0
`define SFQ_W_HI         6
`define SFQ_W_LO         4
// Reset values and page size
`define SFQ_PARAM_RST    8'h00
`define SFQ_PAGE_BYTES   256
`endif

// [src/sfq_frontend.v]
`timescale 1ns/1ps
`include "sfq_consts.vh"
// Functional notes
// [R1] In four-line command mode each byte, opcode included, takes two clocks; the code takes four clocks a byte for BBh after its opcode.
// [R2] Opcodes 06h, 50h, 04h are single byte write-control commands.
// [R3] Status read 05h/35h/15h repeats its byte until chip select rises; ID too.
// [R4] Bytes travel MSB first on one, two or four lines.
// [R5] Page program takes 1..256 bytes; excess wraps within the page.
// [R6] 75h suspends and 7Ah resumes, both single byte.
// [R7] Burst read 0Ch: opcode, three address bytes, dummies, data until deselect.
// [R8] Security area: upper 00h, middle 10h/20h/30h, low byte offset.
// [R9] Dual address input: line one odd bits, line zero even bits.
// [R10] Dual data output: four clocks, line one bits 7,5,3,1.
// [R11] Quad address input: line n carries bits with index mod four n.
// [R12] Quad data: two clocks per byte, upper nibble first.
// [R13] Set-wrap in quad mode: wrap bits on lines 0..2 at seventh clock.
// [R14] 01h with two data bytes writes status bytes one and two.
// [R15] Dummy count in single/dual/quad comes from status byte three bits 1:0; the code uses eight plus those bits.
// [R16] Four-line dummy count comes from read parameter bits 7:4.
// [R17] Four-line wrap length comes from read parameter bits 3:0; the code wraps burst reads at 16 bytes for any nonzero value.
// [R18] Four-line opcode goes as two nibbles, high first; address, data follow.
// [R19] Unknown opcode is ignored until chip select rises.
// [R20] Host keeps chip select low for whole bytes only.
module sfq_frontend #(
    parameter DATA_W = 8
) (
    // Clock and reset
    input  wire              mclk,
    input  wire              rst,
    // Link pins, inputs sampled into mclk
    input  wire              sclk,
    input  wire              cs_n,
    input  wire [3:0]        quad_data_lines_in,
    output reg  [3:0]        quad_data_lines_out,
    output reg  [3:0]        quad_data_lines_oe,
    // Mode and state from the array side
    input  wire              four_line_command_mode,
    input  wire [7:0]        status1,
    input  wire [7:0]        status2,
    input  wire [7:0]        status3,
    input  wire [7:0]        id_byte,
    input  wire [7:0]        array_data,
    // Decoded events and fields
    output reg               write_enable_latch,
    output reg               volatile_wr_enable,
    output reg               suspend_req,
    output reg               resume_req,
    output reg               status_wr,
    output reg  [15:0]       status_wr_data,
    output reg               status_wr_two,
    output reg               page_wr,
    output reg  [23:0]       page_wr_addr,
    output reg  [DATA_W-1:0] page_wr_data,
    output reg  [23:0]       read_addr,
    output reg  [1:0]        sec_reg_sel,
    output reg  [7:0]        read_parameter_byte,
    output reg  [3:0]        dummy_clocks
);
    localparam [5:0] ST_OP = 6'h01, ST_ADDR = 6'h02, ST_IN = 6'h04,
                     ST_DUM = 6'h08, ST_OUT = 6'h10, ST_IGN = 6'h20;

    // Two-flop synchronisers; stage one is read only by stage two
    reg [5:0] sync1, sync2;
    reg       sclk_d;
    always @(posedge mclk) begin
        sync1  <= {sclk, cs_n, quad_data_lines_in};
        sync2  <= sync1;
        sclk_d <= sync2[5];
    end
    wire       s_clk  = sync2[5];
    wire       s_cs_n = sync2[4];
    wire [3:0] s_io   = sync2[3:0];
    wire       rise   = s_clk & ~sclk_d;
    wire       fall   = ~s_clk & sclk_d;

    reg [5:0]  state;
    reg [7:0]  opcode;
    reg [7:0]  shreg;
    reg [3:0]  bitcnt;
    reg [2:0]  bytecnt;
    reg [7:0]  dcnt;
    reg [7:0]  out_byte;
    reg [2:0]  out_cnt;
    reg [1:0]  width;      // 0 single, 1 dual, 2 quad
    reg [7:0]  page_off;
    reg [3:0]  wrapq;
    reg        fresh;
    reg [2:0]  wrap_setting_bits;

    // Bits per transfer clock for the active width
    function [3:0] step;
        input [1:0] w;
        begin
            step = (w == 2'd2) ? 4'd4 : (w == 2'd1) ? 4'd2 : 4'd1;
        end
    endfunction

    // Shift new bits in, MSB first: quad line n = bit n of nibble [R4] [R11] [R9] [R18]
    function [7:0] shift_in;
        input [7:0] s;
        input [1:0] w;
        input [3:0] io;
        begin
            case (w)
                2'd2:    shift_in = {s[3:0], io};             // [R12]
                2'd1:    shift_in = {s[5:0], io[1], io[0]};   // line1 odd, line0 even
                default: shift_in = {s[6:0], io[0]};
            endcase
        end
    endfunction

    wire [7:0] nxt = shift_in(shreg, width, s_io);
    wire [3:0] nbit = bitcnt + step(width);
    wire       byte_done = rise && (nbit >= 4'd8);
    // Dummy count: parameter byte in four-line mode, status3 otherwise
    wire [3:0] dum_sel = four_line_command_mode ?
        read_parameter_byte[`SFQ_P_DUMMY_HI:`SFQ_P_DUMMY_LO] :   // [R16]
        {2'b00, status3[1:0]} + 4'd8;                            // [R15]

    // Main framing engine
    always @(posedge mclk) begin
        if (rst || s_cs_n) begin
            state <= ST_OP;
            shreg <= 8'h00; bitcnt <= 4'h0; bytecnt <= 3'h0;
            width <= four_line_command_mode ? 2'd2 : 2'd0;   // [R1] [R18]
            quad_data_lines_oe <= 4'h0;
            out_cnt <= 3'h0;
            page_off <= 8'h00;
            fresh <= 1'b1;
            if (rst) begin
                write_enable_latch <= 1'b0; volatile_wr_enable <= 1'b0;
                read_parameter_byte <= `SFQ_PARAM_RST;
                status_wr_data <= 16'h0000; page_wr_addr <= 24'h000000;
                read_addr <= 24'h000000; opcode <= 8'h00; out_byte <= 8'h00;
                dcnt <= 8'h00; sec_reg_sel <= 2'b00; wrapq <= 4'h0;
                quad_data_lines_out <= 4'h0; page_wr_data <= {DATA_W{1'b0}};
                status_wr <= 1'b0; status_wr_two <= 1'b0;
                dummy_clocks <= 4'h0;
                wrap_setting_bits <= 3'h0;
            end else if (!fresh && state == ST_IN && opcode == `SFQ_OP_WRSR1
                         && bytecnt != 3'h0) begin
                status_wr     <= 1'b1;                        // [R14]
                status_wr_two <= (bytecnt == 3'd2);
            end else
                status_wr <= 1'b0;                            // One cycle only while deselected
            suspend_req <= 1'b0; resume_req <= 1'b0; page_wr <= 1'b0;
        end else begin
            fresh <= 1'b0;
            status_wr <= 1'b0; suspend_req <= 1'b0; resume_req <= 1'b0;
            page_wr <= 1'b0;
            dummy_clocks <= dum_sel;
            if (rise && state != ST_OUT && state != ST_DUM && state != ST_IGN) begin
                shreg  <= nxt;
                bitcnt <= byte_done ? 4'h0 : nbit;
            end
            case (state)
                ST_OP: if (byte_done) begin
                    opcode <= nxt;
                    bytecnt <= 3'h0;
                    case (nxt)
                        `SFQ_OP_WREN:  write_enable_latch <= 1'b1;      // [R2]
                        `SFQ_OP_WRDI:  write_enable_latch <= 1'b0;      // [R2]
                        `SFQ_OP_VWREN: volatile_wr_enable <= 1'b1;      // [R2]
                        `SFQ_OP_SUSP:  suspend_req <= 1'b1;             // [R6]
                        `SFQ_OP_RESUME: resume_req <= 1'b1;             // [R6]
                        `SFQ_OP_RDSR1, `SFQ_OP_RDSR2, `SFQ_OP_RDSR3, `SFQ_OP_JEDEC: begin
                            state <= ST_OUT;                            // [R3]
                            out_byte <= (nxt == `SFQ_OP_RDSR1) ? status1 :
                                        (nxt == `SFQ_OP_RDSR2) ? status2 :
                                        (nxt == `SFQ_OP_RDSR3) ? status3 : id_byte;
                            out_cnt <= 3'h0;
                        end
                        `SFQ_OP_WRSR1, `SFQ_OP_SETPARAM: state <= ST_IN;
                        `SFQ_OP_SETWRAP: begin
                            state <= ST_IN;
                            width <= 2'd2;                              // [R13]
                        end
                        `SFQ_OP_PP, `SFQ_OP_FREAD, `SFQ_OP_BURST, `SFQ_OP_DIOREAD,
                        `SFQ_OP_QIOREAD, `SFQ_OP_RDSEC: begin
                            state <= ST_ADDR;
                            if (nxt == `SFQ_OP_QIOREAD)
                                width <= 2'd2;                          // [R11]
                            else if (nxt == `SFQ_OP_DIOREAD)
                                width <= 2'd1;                          // [R9]
                        end
                        default: state <= ST_IGN;                       // [R19]
                    endcase
                end
                ST_ADDR: if (byte_done) begin
                    bytecnt <= bytecnt + 3'd1;
                    case (bytecnt)
                        3'd0: read_addr[23:16] <= nxt;
                        3'd1: read_addr[15:8]  <= nxt;
                        3'd2: begin
                            read_addr[7:0] <= nxt;
                            page_wr_addr <= {read_addr[23:8], nxt};
                            page_off <= nxt;
                            // Security register select [R8]
                            if (read_addr[23:16] == `SFQ_SEC_HI)
                                sec_reg_sel <= (read_addr[15:8] == `SFQ_SEC_R1) ? 2'd1 :
                                               (read_addr[15:8] == `SFQ_SEC_R2) ? 2'd2 :
                                               (read_addr[15:8] == `SFQ_SEC_R3) ? 2'd3 : 2'd0;
                            else
                                sec_reg_sel <= 2'd0;
                            if (opcode == `SFQ_OP_PP) begin
                                state <= ST_IN;
                                bytecnt <= 3'h0;
                            end else if (opcode == `SFQ_OP_QIOREAD ||
                                         opcode == `SFQ_OP_DIOREAD) begin
                                bytecnt <= 3'd3;                        // mode byte next
                                wrapq   <= {1'b0, wrap_setting_bits};   // [R13]
                            end else begin
                                state <= ST_DUM;                        // [R7]
                                dcnt <= {4'h0, dum_sel};
                                wrapq <= read_parameter_byte[`SFQ_P_WRAP_HI:`SFQ_P_WRAP_LO]; // [R17]
                            end
                        end
                        default: begin                                  // mode byte [R9]
                            state <= ST_DUM;
                            dcnt <= {4'h0, dum_sel};
                        end
                    endcase
                end
                ST_IN: if (byte_done) begin
                    if (bytecnt != 3'd7)
                        bytecnt <= bytecnt + 3'd1;
                    if (opcode == `SFQ_OP_SETPARAM)
                        read_parameter_byte <= nxt;
                    else if (opcode == `SFQ_OP_SETWRAP) begin
                        // Only the seventh clock carries wrap bits; the rest is filler [R13]
                        if (bytecnt == 3'd3)
                            wrap_setting_bits <= nxt[`SFQ_W_HI:`SFQ_W_LO];
                    end else if (opcode == `SFQ_OP_WRSR1) begin
                        if (bytecnt == 3'd0) status_wr_data[7:0] <= nxt;
                        else status_wr_data[15:8] <= nxt;               // [R14]
                    end else begin
                        page_wr <= 1'b1;                                // [R5]
                        page_wr_data <= nxt;
                        page_wr_addr <= {page_wr_addr[23:8], page_off};
                        page_off <= page_off + 8'h01;                   // wraps in page [R5]
                    end
                end
                ST_DUM: if (fall) begin
                    if (dcnt == 8'h00 || dcnt == 8'h01) begin
                        state <= ST_OUT;
                        out_byte <= array_data;
                        out_cnt <= 3'h0;
                    end else
                        dcnt <= dcnt - 8'h01;
                end
                ST_OUT: if (fall) begin
                    // Drive on falling edge, MSB first [R4] [R10] [R12]
                    case (width)
                        2'd2: begin
                            quad_data_lines_oe  <= 4'hF;
                            quad_data_lines_out <= out_cnt[0] ? out_byte[3:0] : out_byte[7:4];
                        end
                        2'd1: begin
                            quad_data_lines_oe  <= 4'h3;
                            quad_data_lines_out <= {2'b00, out_byte[7 - 2 * out_cnt[1:0]],
                                                    out_byte[6 - 2 * out_cnt[1:0]]};
                        end
                        default: begin
                            quad_data_lines_oe  <= 4'h2;
                            quad_data_lines_out <= {2'b00, out_byte[3'd7 - out_cnt], 1'b0};
                        end
                    endcase
                    out_cnt <= out_cnt + 3'h1;
                    if ((width == 2'd2 && out_cnt[0]) || (width == 2'd1 && out_cnt[1:0] == 2'd3)
                        || out_cnt == 3'd7) begin
                        out_cnt <= 3'h0;
                        // Status and ID repeat; array reads advance
                        if (opcode != `SFQ_OP_RDSR1 && opcode != `SFQ_OP_RDSR2 &&
                            opcode != `SFQ_OP_RDSR3 && opcode != `SFQ_OP_JEDEC) begin
                            out_byte <= array_data;                     // [R7]
                            // Simplified wrap: any nonzero setting keeps burst and quad I/O reads in 16 bytes
                            read_addr <= (wrapq != 4'h0 && (opcode == `SFQ_OP_BURST ||
                                          opcode == `SFQ_OP_QIOREAD)) ?
                                {read_addr[23:4], read_addr[3:0] + 4'h1} : read_addr + 24'h1;
                        end
                    end
                end
                default: state <= ST_IGN;                               // [R19]
            endcase
        end
    end
endmodule // sfq_frontend
